// ---- rtl/acs_pkg.sv ----
package acs_pkg;
   // Clock and time unit: one time unit is half of one clock period.
   localparam int CLK_PERIOD_PS = 4000;
   localparam int HALF_PS = CLK_PERIOD_PS / 2;
   localparam int HALF_PER_CLK = CLK_PERIOD_PS / HALF_PS;

   // Conversion clock periods in time units.
   localparam int TCC_FAST_HALF = 24;
   localparam int TCC_MID_HALF = 48;
   localparam int TCC_SLOW_HALF = 96;
   localparam int TRANSFER_HALF = 4;

   localparam int CNT_W = 11;
   localparam logic [CNT_W-1:0] TCC_FAST_CYC = CNT_W'(TCC_FAST_HALF / HALF_PER_CLK);
   localparam logic [CNT_W-1:0] TCC_MID_CYC = CNT_W'(TCC_MID_HALF / HALF_PER_CLK);
   localparam logic [CNT_W-1:0] TCC_SLOW_CYC = CNT_W'(TCC_SLOW_HALF / HALF_PER_CLK);
   localparam logic [CNT_W-1:0] TRANSFER_CYC = CNT_W'(TRANSFER_HALF / HALF_PER_CLK);

   // Conversion clock select codes.
   localparam logic [1:0] CONV_SEL_FAST = 2'h0;
   localparam logic [1:0] CONV_SEL_RSVD = 2'h1;
   localparam logic [1:0] CONV_SEL_SLOW = 2'h2;
   localparam logic [1:0] CONV_SEL_MID = 2'h3;

   // Control register layout: timing fields sit in the upper four bits.
   localparam int CTRL_W = 16;
   localparam int CONV_SEL_LSB = 14;
   localparam int SAMPLE_SEL_LSB = 12;

   // Step counts per phase.
   localparam int RES_W = 10;
   localparam logic [3:0] SAMPLE_STEPS = 4'h2;
   localparam logic [3:0] DECIDE_STEPS = 4'ha;
   localparam logic [3:0] EQUAL_STEPS = 4'h4;
   localparam logic [RES_W-1:0] RES_ZERO = 10'h000;
   localparam logic [RES_W-1:0] RES_FULL = 10'h3ff;

   typedef enum logic [2:0] {
      ACS_IDLE,
      ACS_SAMPLE,
      ACS_DECIDE,
      ACS_EQUAL,
      ACS_TRANSFER
   } acs_state_t;
endpackage : acs_pkg

// ---- rtl/acs_step_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module acs_step_timer (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic srst_in,
   // Control
   input wire logic hold_in,
   input wire logic [acs_pkg::CNT_W-1:0] len_in,
   // Step end
   output logic last_out
);
   logic [acs_pkg::CNT_W-1:0] cnt_r;
   logic [acs_pkg::CNT_W-1:0] cnt_nxt;

   // The count restarts itself at each step end so steps repeat back to back.
   assign last_out = !hold_in && (cnt_r == len_in - acs_pkg::CNT_W'(1));
   assign cnt_nxt = (hold_in || last_out) ? '0 : cnt_r + acs_pkg::CNT_W'(1);

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule : acs_step_timer
`default_nettype wire

// ---- rtl/acs_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// - A started conversion first samples the input for two sample-clock periods.
// - Ten bit decisions follow, one per conversion-clock period, giving ten result bits.
// - Four further conversion-clock steps follow for level equalization.
// - A conversion lasts exactly 14 conversion clocks plus 2 sample clocks plus 4 time units.
// - The result register is loaded as the last step within the conversion time.
// - The timing fields are taken from the upper four bits of the control register.
// - Conversion clock is 24, 48 or 96 time units for codes 00, 11, 10; code 01 is reserved.
// - The sample clock is the conversion clock times 1, 2, 4 or 8 for codes 00 to 11.
// - After sampling the held value is used, so later input changes have no effect.
// - An input below ground gives all zeros and one above reference gives all ones.
// - All phase lengths are given in half clock periods and counted in whole system clock cycles.
module acs_sequencer (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic srst_in,
   // Control
   input wire logic start_in,
   input wire logic [acs_pkg::CTRL_W-1:0] converter_control_reg_in,
   // Analog front end
   input wire logic cmp_high_in,
   input wire logic below_gnd_in,
   input wire logic above_ref_in,
   output logic sample_hold_out,
   output logic [acs_pkg::RES_W-1:0] trial_code_out,
   // Status and result
   output logic busy_out,
   output logic done_out,
   output logic [acs_pkg::RES_W-1:0] result_out
);
   acs_pkg::acs_state_t state_r;
   acs_pkg::acs_state_t state_nxt;
   logic [1:0] conv_clock_select_r;
   logic [1:0] sample_clock_select_r;
   logic [3:0] step_r;
   logic [3:0] step_nxt;
   logic [acs_pkg::RES_W-1:0] sar_r;
   logic [acs_pkg::RES_W-1:0] trial_w;
   logic [acs_pkg::RES_W-1:0] result_r;
   logic done_r;
   logic [2:0] cmp_sync_r;
   logic [1:0] below_sync_r;
   logic [1:0] above_sync_r;
   logic below_r;
   logic above_r;
   logic [acs_pkg::CNT_W-1:0] tcc_w;
   logic [acs_pkg::CNT_W-1:0] tsc_w;
   logic [acs_pkg::CNT_W-1:0] len_w;
   logic step_last_w;
   logic phase_last_w;
   logic start_ok_w;
   logic [acs_pkg::RES_W-1:0] final_w;

   // Reserved code 01 falls back to the fastest period.
   function automatic logic [acs_pkg::CNT_W-1:0] tcc_cycles(input logic [1:0] sel);
      case (sel)
         acs_pkg::CONV_SEL_MID: tcc_cycles = acs_pkg::TCC_MID_CYC;
         acs_pkg::CONV_SEL_SLOW: tcc_cycles = acs_pkg::TCC_SLOW_CYC;
         default: tcc_cycles = acs_pkg::TCC_FAST_CYC;
      endcase
   endfunction : tcc_cycles

   assign tcc_w = tcc_cycles(conv_clock_select_r);
   assign tsc_w = tcc_w << sample_clock_select_r;
   assign len_w = (state_r == acs_pkg::ACS_SAMPLE) ? tsc_w :
                  (state_r == acs_pkg::ACS_TRANSFER) ? acs_pkg::TRANSFER_CYC : tcc_w;

   acs_step_timer u_timer (
      .clk_sys_in(clk_sys_in),
      .srst_in(srst_in),
      .hold_in(state_r == acs_pkg::ACS_IDLE),
      .len_in(len_w),
      .last_out(step_last_w)
   );

   assign start_ok_w = start_in && (state_r == acs_pkg::ACS_IDLE);
   assign phase_last_w = step_last_w &&
      (((state_r == acs_pkg::ACS_SAMPLE) && (step_r == acs_pkg::SAMPLE_STEPS - 4'h1)) ||
       ((state_r == acs_pkg::ACS_DECIDE) && (step_r == acs_pkg::DECIDE_STEPS - 4'h1)) ||
       ((state_r == acs_pkg::ACS_EQUAL) && (step_r == acs_pkg::EQUAL_STEPS - 4'h1)) ||
       (state_r == acs_pkg::ACS_TRANSFER));
   assign step_nxt = (phase_last_w || state_r == acs_pkg::ACS_IDLE) ? 4'h0 :
                     step_last_w ? step_r + 4'h1 : step_r;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         acs_pkg::ACS_IDLE: begin
            if (start_ok_w) begin
               state_nxt = acs_pkg::ACS_SAMPLE;
            end
         end
         acs_pkg::ACS_SAMPLE: begin
            if (phase_last_w) begin
               state_nxt = acs_pkg::ACS_DECIDE;
            end
         end
         acs_pkg::ACS_DECIDE: begin
            if (phase_last_w) begin
               state_nxt = acs_pkg::ACS_EQUAL;
            end
         end
         acs_pkg::ACS_EQUAL: begin
            if (phase_last_w) begin
               state_nxt = acs_pkg::ACS_TRANSFER;
            end
         end
         acs_pkg::ACS_TRANSFER: begin
            if (phase_last_w) begin
               state_nxt = acs_pkg::ACS_IDLE;
            end
         end
         default: state_nxt = acs_pkg::ACS_IDLE;
      endcase
   end

   // Trial code: decided bits plus the bit under test, MSB first.
   genvar gi;
   generate
      for (gi = 0; gi < acs_pkg::RES_W; gi++) begin : g_trial
         assign trial_w[gi] = sar_r[gi] || ((state_r == acs_pkg::ACS_DECIDE) &&
            (step_r == 4'(acs_pkg::RES_W - 1 - gi)));
      end
   endgenerate

   assign final_w = below_r ? acs_pkg::RES_ZERO :
                    above_r ? acs_pkg::RES_FULL : sar_r;

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         cmp_sync_r <= '0;
         below_sync_r <= '0;
         above_sync_r <= '0;
      end else begin
         cmp_sync_r <= {cmp_sync_r[1:0], cmp_high_in};
         below_sync_r <= {below_sync_r[0], below_gnd_in};
         above_sync_r <= {above_sync_r[0], above_ref_in};
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         state_r <= acs_pkg::ACS_IDLE;
         step_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         step_r <= step_nxt;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         conv_clock_select_r <= 2'h0;
         sample_clock_select_r <= 2'h0;
      end else if (start_ok_w) begin
         conv_clock_select_r <= converter_control_reg_in[acs_pkg::CONV_SEL_LSB +: 2];
         sample_clock_select_r <= converter_control_reg_in[acs_pkg::SAMPLE_SEL_LSB +: 2];
      end
   end

   // Range flags are caught at the end of sampling, with the held value.
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         below_r <= 1'b0;
         above_r <= 1'b0;
      end else if (state_r == acs_pkg::ACS_SAMPLE && phase_last_w) begin
         below_r <= below_sync_r[1];
         above_r <= above_sync_r[1];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in || start_ok_w) begin
         sar_r <= '0;
      end else if (state_r == acs_pkg::ACS_DECIDE && step_last_w) begin
         sar_r <= cmp_sync_r[2] ? trial_w : sar_r;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         result_r <= '0;
         done_r <= 1'b0;
      end else begin
         done_r <= (state_r == acs_pkg::ACS_TRANSFER) && phase_last_w;
         if ((state_r == acs_pkg::ACS_TRANSFER) && phase_last_w) begin
            result_r <= final_w;
         end
      end
   end

   assign sample_hold_out = (state_r == acs_pkg::ACS_SAMPLE);
   assign trial_code_out = trial_w;
   assign busy_out = (state_r != acs_pkg::ACS_IDLE);
   assign done_out = done_r;
   assign result_out = result_r;
endmodule : acs_sequencer
`default_nettype wire

// ---- tb/acs_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module acs_checker (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic srst_in,
   // Observed ports
   input wire logic start_in,
   input wire logic [acs_pkg::CTRL_W-1:0] converter_control_reg_in,
   input wire logic sample_hold_out,
   input wire logic busy_out,
   input wire logic done_out,
   input wire logic [acs_pkg::RES_W-1:0] result_out
);
   logic acc;
   logic [1:0] cs_r;
   logic [1:0] ss_r;
   logic [10:0] n_r;
   logic [10:0] s_r;
   logic [10:0] tcc;
   logic [10:0] tsc;
   assign acc = start_in && !busy_out;
   assign tcc = cs_r == 2'h2 ? 11'h030 : cs_r == 2'h3 ? 11'h018 : 11'h00c;
   assign tsc = tcc << ss_r;
   // Counts cycles and sample cycles since the accepted start.
   always_ff @(posedge clk_sys_in) begin
      if (srst_in || acc) begin
         cs_r <= converter_control_reg_in[15:14];
         ss_r <= converter_control_reg_in[13:12];
         n_r <= 11'h000;
         s_r <= 11'h000;
      end else begin
         n_r <= n_r + 11'h001;
         s_r <= s_r + {10'h000, sample_hold_out};
      end
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (srst_in);
   sequence s_take;
      start_in && !busy_out;
   endsequence
   sequence s_track;
      sample_hold_out [*8];
   endsequence
   a_take_track: assert property (s_take |=> s_track)
      else $error("sampling did not follow start");
   a_sample_len: assert property ($fell(sample_hold_out) |-> s_r == (tsc << 1))
      else $error("sample phase length wrong");
   a_conv_time: assert property (done_out |-> n_r == (tsc << 1) + tcc * 11'h00e + 11'h002)
      else $error("conversion length wrong");
   a_take_busy: assert property (s_take |=> busy_out && !done_out)
      else $error("busy not raised after start");
   a_busy_stays: assert property (busy_out |=> busy_out || done_out)
      else $error("busy dropped without done");
   a_done_pulse: assert property (done_out |=> !done_out)
      else $error("done longer than one cycle");
   a_done_idle: assert property (done_out |-> !busy_out && $past(busy_out))
      else $error("done outside a conversion");
   a_result_hold: assert property (!done_out |-> $stable(result_out))
      else $error("result changed without done");
   a_idle_hold: assert property (!busy_out |-> !sample_hold_out)
      else $error("sampling while idle");
endmodule : acs_checker
bind acs_sequencer acs_checker chk (.clk_sys_in, .srst_in, .start_in, .converter_control_reg_in,
   .sample_hold_out, .busy_out, .done_out, .result_out);
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_sys_in = 1'b0;
   logic srst_in = 1'b1;
   logic start_in = 1'b0;
   logic [15:0] converter_control_reg_in = 16'h0000;
   logic below_gnd_in = 1'b0;
   logic above_ref_in = 1'b0;
   logic [9:0] ain = 10'h000;
   logic [9:0] held = 10'h000;
   logic cmp_high_in;
   logic sample_hold_out, busy_out, done_out;
   logic [9:0] trial_code_out, result_out;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   // Ideal comparator against the held analog value.
   assign cmp_high_in = held >= trial_code_out;
   always @(posedge clk_sys_in) begin
      if (sample_hold_out) held <= ain;
   end
   always #2 clk_sys_in = ~clk_sys_in;
   acs_sequencer dut (.clk_sys_in, .srst_in, .start_in, .converter_control_reg_in,
      .cmp_high_in, .below_gnd_in, .above_ref_in, .sample_hold_out, .trial_code_out,
      .busy_out, .done_out, .result_out);
   task automatic end_sim;
      $display("checks_done=%0d err_total=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   task automatic chk_res(input logic [9:0] got, input logic [9:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t result %h expected %h", $time, got, exp);
      end
   endtask : chk_res
   task automatic chk_len(input int got, input int exp);
      checks_done++;
      if (got != exp) begin
         err_total++;
         $display("MISMATCH %0t length %0d expected %0d", $time, got, exp);
      end
   endtask : chk_len
   // Range flags drop once sampling ends; the held decision must survive.
   task automatic conv(input logic [15:0] ctrl, input logic [9:0] v, input logic bg,
      input logic ar, input logic keep, input logic [9:0] exp);
      int n;
      int tcc;
      logic moved;
      tcc = ctrl[15:14] == 2'h2 ? 96 : ctrl[15:14] == 2'h3 ? 48 : 24;
      converter_control_reg_in = ctrl;
      ain = v;
      below_gnd_in = bg;
      above_ref_in = ar;
      start_in = 1'b1;
      @(posedge clk_sys_in);
      #1;
      start_in = keep;
      n = 0;
      moved = 1'b0;
      while (done_out !== 1'b1 && n < 2000) begin
         @(posedge clk_sys_in);
         #1;
         n++;
         // Once held, the input moves away; the result must not follow it.
         if (sample_hold_out === 1'b0 && !moved) begin
            moved = 1'b1;
            below_gnd_in = 1'b0;
            above_ref_in = 1'b0;
            ain = ~v;
         end
      end
      chk_len(n, (14 * tcc + 2 * (tcc << ctrl[13:12]) + 4) / 2);
      chk_res(result_out, exp);
   endtask : conv
   task automatic t_modes;
      for (int i = 0; i < 16; i++) begin
         // Reserved conversion code 01 is never programmed; 00 runs in its place.
         conv({(i[3:2] == 2'h1) ? 2'h0 : i[3:2], i[1:0], 12'hfff}, {i[3:0], i[3:0], 2'h2},
            1'b0, 1'b0, 1'b0,
            {i[3:0], i[3:0], 2'h2});
      end
   endtask : t_modes
   task automatic t_sat;
      conv(16'h0000, 10'h3ff, 1'b1, 1'b0, 1'b0, 10'h000);
      conv(16'h1000, 10'h000, 1'b0, 1'b1, 1'b0, 10'h3ff);
      conv(16'h0000, 10'h155, 1'b1, 1'b1, 1'b0, 10'h000);
      conv(16'h0000, 10'h3ff, 1'b0, 1'b0, 1'b0, 10'h3ff);
      conv(16'h0000, 10'h000, 1'b0, 1'b0, 1'b0, 10'h000);
   endtask : t_sat
   // Start stays high through the first run and is taken on its done cycle.
   task automatic t_b2b;
      conv(16'hc000, 10'h2aa, 1'b0, 1'b0, 1'b1, 10'h2aa);
      conv(16'h3000, 10'h0f0, 1'b0, 1'b0, 1'b0, 10'h0f0);
   endtask : t_b2b
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end
   initial begin
      repeat (20) @(posedge clk_sys_in);
      #1;
      srst_in = 1'b0;
      t_modes();
      t_sat();
      t_b2b();
      end_sim();
   end
endmodule : testbench
`default_nettype wire
